// *** seq_defs.svh ***
// Constants of the start, stop and restart sequencer
`ifndef SEQ_DEFS_SVH
`define SEQ_DEFS_SVH

// ****************************************
// Time base
// ****************************************
`define SEQ_CLK_KHZ 50000
`define SEQ_TICK_MS 10
`define SEQ_LOSS_MS 8
`define SEQ_QUIET_MIN 10
`define SEQ_TPS (1000 / `SEQ_TICK_MS)
`define SEQ_TPD (`SEQ_TPS / 10)
`define SEQ_QUIET_TICKS (`SEQ_QUIET_MIN * 60 * `SEQ_TPS)

// ****************************************
// Register offsets
// ****************************************
`define SEQ_CTRL_OFS 8'h00
`define SEQ_TIME_OFS 8'h04
`define SEQ_BB_OFS 8'h08
`define SEQ_DCB_OFS 8'h0C
`define SEQ_DCS_OFS 8'h10
`define SEQ_FMIN_OFS 8'h14
`define SEQ_STAT_OFS 8'h18

// ****************************************
// Field positions
// ****************************************
`define SEQ_RESTART_EN 0
`define SEQ_DIRECT_DIS 1
`define SEQ_MODE 3:2
`define SEQ_PM 4
`define SEQ_VEC 5
`define SEQ_CLR 6
`define SEQ_RT_SEC 12:0
`define SEQ_RT_LIM 19:16
`define SEQ_BB_DS 5:0
`define SEQ_DLY_DS 27:16
`define SEQ_DC_CUR 6:0
`define SEQ_DC_THR 17:8
`define SEQ_DC_STOP 9:0
`define SEQ_DC_START 29:16
`define SEQ_FMIN 15:0

// ****************************************
// Write masks and reset values
// ****************************************
`define SEQ_CTRL_MASK 32'h0000003F
`define SEQ_TIME_MASK 32'h000F1FFF
`define SEQ_BB_MASK 32'h0FFF003F
`define SEQ_DCB_MASK 32'h0003FF7F
`define SEQ_DCS_MASK 32'h3FFF03FF
`define SEQ_FMIN_MASK 32'h0000FFFF
`define SEQ_BB_RST 32'h000A0005
`define SEQ_FMIN_RST 32'h00000096

`endif

// *** seq_pkg.sv ***
// Types of the start, stop and restart sequencer
package seq_pkg;

   typedef enum logic [3:0] {
      ST_POWERUP = 4'h0,
      ST_PU_DELAY = 4'h1,
      ST_STOP = 4'h2,
      ST_START_DCB = 4'h3,
      ST_RUN = 4'h4,
      ST_DECEL = 4'h5,
      ST_STOP_DCB = 4'h6,
      ST_BASEBLOCK = 4'h7,
      ST_SEARCH = 4'h8,
      ST_TRIPPED = 4'h9
   } seq_state_t;

   typedef enum logic [1:0] {
      BB_COAST = 2'h0,
      BB_DCSTOP = 2'h1,
      BB_FAULT = 2'h2,
      BB_POWER = 2'h3
   } bb_kind_t;

   typedef struct packed {
      seq_state_t state;
      bb_kind_t bbk;
      logic [13:0] s1;
      logic [13:0] s2;
      logic [13:0] s3;
      logic [13:0] filt;
      logic [18:0] tick_cnt;
      logic tick;
      logic [4:0] blink;
      logic [19:0] tmr;
      logic [18:0] loss_cnt;
      logic [15:0] quiet;
      logic [3:0] attempts;
      logic flt_low;
      logic flt_rt;
      logic flt_other;
      logic blocked;
      logic key_q;
      logic [31:0] ctrl;
      logic [31:0] tim;
      logic [31:0] bbr;
      logic [31:0] dcbr;
      logic [31:0] dcsr;
      logic [31:0] fminr;
      logic [31:0] rdata;
      logic ack;
      logic wreq;
      logic oe;
      logic bblk;
      logic dcb;
      logic dec;
      logic minf;
      logic srch;
      logic fact;
      logic fcon;
      logic flash;
      logic [6:0] cur;
   } seq_regs_t;

endpackage

// *** drive_start_stop_restart_sequencer.sv ***
// Start, stop, restart and DC braking sequencer of a motor drive
// Notes on behaviour
// - Restart off: supply loss over 8ms trips
// - Restart on: resume after momentary supply loss
// - Restart interval is larger of baseblock, restart time
// - Restart attempt limit settable zero to ten
// - Ten quiet minutes after restart clear attempts
// - Fault clear or power cycle clears attempts
// - Fault disables output, ignores run during baseblock
// - After baseblock, clear fault then speed search
// - Attempts over limit: output off, fault contact
// - Only listed faults restart; supply loss unlimited
// - Direct start at power-up after set delay
// - Direct start off: block, flash, need run re-press
// - DC braking begins at threshold frequency
// - DC braking current zero to hundred percent
// - Stop braking time; zero skips stop braking
// - Start braking time; zero starts at minimum frequency
// - Braking needs current and time above zero
// - Threshold below minimum frequency uses minimum
// - No DC braking under sensor vector control
// - Input terminal command applies DC braking
// - Four stop modes (code: modes 1 and 3 both coast); permanent magnet decelerates only
// - Decelerate, then brake at threshold and stop
// - Coast: output off, run ignored during baseblock
// - Minimum baseblock time 0.1 to 5.0 s
`include "seq_defs.svh"
module drive_start_stop_restart_sequencer
   import seq_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = `SEQ_CLK_KHZ * `SEQ_TICK_MS,
   parameter int unsigned LOSS_CYCLES = `SEQ_CLK_KHZ * `SEQ_LOSS_MS
)
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic rstn_in,
   // Avalon-MM slave
   input wire logic [7:0] address_in,
   input wire logic read_in,
   input wire logic write_in,
   input wire logic [31:0] writedata_in,
   input wire logic [3:0] byteenable_in,
   output logic [31:0] readdata_out,
   output logic waitrequest_out,
   // Command and supply pins
   input wire logic run_in,
   input wire logic supply_ok_in,
   input wire logic fault_reset_in,
   input wire logic dc_brake_cmd_in,
   // Fault pins
   input wire logic overcurrent_fault_in,
   input wire logic overvoltage_fault_in,
   input wire logic motor_overload_fault_in,
   input wire logic drive_overload_fault_in,
   input wire logic low_torque_fault_in,
   input wire logic high_torque_fault_in,
   input wire logic input_phase_loss_fault_in,
   input wire logic output_phase_loss_fault_in,
   input wire logic ground_fault_in,
   input wire logic other_fault_in,
   // Power stage side, same clock
   input wire logic [15:0] out_freq_in,
   input wire logic speed_search_done_in,
   output logic output_enable_out,
   output logic baseblock_out,
   output logic dc_brake_out,
   output logic [6:0] dc_brake_current_out,
   output logic decel_req_out,
   output logic start_min_freq_out,
   output logic speed_search_out,
   output logic fault_active_out,
   output logic fault_contact_out,
   output logic powerup_run_blocked_indication_out
);

   // ****************************************
   // State and helpers
   // ****************************************
   localparam seq_regs_t RST = '{state: ST_POWERUP, bbk: BB_COAST,
      bbr: `SEQ_BB_RST, fminr: `SEQ_FMIN_RST, wreq: 1'b1, bblk: 1'b1,
      default: '0};

   seq_regs_t s;
   seq_regs_t n;
   logic [13:0] pins;
   logic run, sok, key, dcc, vec, req, loss_long, rt, oth;
   logic clr, fault_now, do_start, start_min, dcs_en, dcp_en, running;
   logic [1:0] mode;
   logic [15:0] thr_eff;
   logic [19:0] bb_t, rt_t, ivl;

   function automatic logic [31:0] merge(input logic [31:0] o,
      input logic [31:0] w, input logic [3:0] be);
      logic [31:0] r;
      r = o;
      for (int i = 0; i < 4; i++)
      begin
         if (be[i]) r[8*i +: 8] = w[8*i +: 8];
      end
      return r;
   endfunction

   assign pins = {other_fault_in, ground_fault_in,
      output_phase_loss_fault_in, input_phase_loss_fault_in,
      high_torque_fault_in, low_torque_fault_in, drive_overload_fault_in,
      motor_overload_fault_in, overvoltage_fault_in, overcurrent_fault_in,
      dc_brake_cmd_in, fault_reset_in, supply_ok_in, run_in};

   // ****************************************
   // Next state
   // ****************************************
   always_comb
   begin
      n = s;
      clr = 1'b0;
      fault_now = 1'b0;
      do_start = 1'b0;
      start_min = 1'b0;
      run = s.filt[0];
      sok = s.filt[1];
      key = s.filt[2];
      dcc = s.filt[3];
      rt = |s.filt[12:4];
      oth = s.filt[13];
      vec = s.ctrl[`SEQ_VEC];
      req = read_in | write_in;
      loss_long = s.loss_cnt == 19'(LOSS_CYCLES);
      mode = s.ctrl[`SEQ_PM] ? 2'h0 : s.ctrl[`SEQ_MODE];
      // Braking counts as enabled only with current and time set
      dcs_en = s.dcbr[`SEQ_DC_CUR] != '0 && s.dcsr[`SEQ_DC_STOP] != '0 &&
         !vec;
      dcp_en = s.dcbr[`SEQ_DC_CUR] != '0 && s.dcsr[`SEQ_DC_START] != '0 &&
         !vec;
      thr_eff = (16'(s.dcbr[`SEQ_DC_THR]) < s.fminr[`SEQ_FMIN]) ?
         s.fminr[`SEQ_FMIN] : 16'(s.dcbr[`SEQ_DC_THR]);
      bb_t = 20'(s.bbr[`SEQ_BB_DS] * `SEQ_TPD);
      rt_t = 20'(s.tim[`SEQ_RT_SEC] * `SEQ_TPS);
      ivl = (rt_t > bb_t) ? rt_t : bb_t;
      running = s.state inside {ST_START_DCB, ST_RUN, ST_DECEL,
         ST_STOP_DCB, ST_SEARCH};

      // Three-stage pin sampler; a level counts once the last two stages agree
      n.s1 = pins;
      n.s2 = s.s1;
      n.s3 = s.s2;
      if (s.s2 == s.s3) n.filt = s.s3;

      // Common tick drives every sequencer timer except the supply loss counter
      n.tick = 1'b0;
      if (s.tick_cnt == 19'(TICK_CYCLES - 1))
      begin
         n.tick_cnt = '0;
         n.tick = 1'b1;
      end
      else
         n.tick_cnt = s.tick_cnt + 19'h00001;
      if (s.tick) n.blink = s.blink + 5'h01;
      if (s.tick && s.tmr != '0) n.tmr = s.tmr - 20'h00001;
      if (sok) n.loss_cnt = '0;
      else if (!loss_long) n.loss_cnt = s.loss_cnt + 19'h00001;

      // Avalon slave: one wait cycle, then one cycle with waitrequest low
      n.ack = req & ~s.ack;
      n.wreq = ~n.ack;
      if (req & ~s.ack)
      begin
         unique case (address_in)
            `SEQ_CTRL_OFS: n.rdata = s.ctrl;
            `SEQ_TIME_OFS: n.rdata = s.tim;
            `SEQ_BB_OFS: n.rdata = s.bbr;
            `SEQ_DCB_OFS: n.rdata = s.dcbr;
            `SEQ_DCS_OFS: n.rdata = s.dcsr;
            `SEQ_FMIN_OFS: n.rdata = s.fminr;
            `SEQ_STAT_OFS: n.rdata = {19'h00000, s.fcon, s.blocked,
               s.flt_other, s.flt_rt, s.flt_low, s.attempts, s.state};
            default: n.rdata = '0;
         endcase
      end
      if (write_in & s.ack)
      begin
         unique case (address_in)
            `SEQ_CTRL_OFS: n.ctrl = merge(s.ctrl, writedata_in,
               byteenable_in) & `SEQ_CTRL_MASK;
            `SEQ_TIME_OFS: n.tim = merge(s.tim, writedata_in,
               byteenable_in) & `SEQ_TIME_MASK;
            `SEQ_BB_OFS: n.bbr = merge(s.bbr, writedata_in,
               byteenable_in) & `SEQ_BB_MASK;
            `SEQ_DCB_OFS: n.dcbr = merge(s.dcbr, writedata_in,
               byteenable_in) & `SEQ_DCB_MASK;
            `SEQ_DCS_OFS: n.dcsr = merge(s.dcsr, writedata_in,
               byteenable_in) & `SEQ_DCS_MASK;
            `SEQ_FMIN_OFS: n.fminr = merge(s.fminr, writedata_in,
               byteenable_in) & `SEQ_FMIN_MASK;
            default: ;
         endcase
      end

      // Fault clear from terminal edge or software strobe
      n.key_q = key;
      clr = (key & ~s.key_q) | (write_in & s.ack &
         address_in == `SEQ_CTRL_OFS & byteenable_in[0] &
         writedata_in[`SEQ_CLR]);
      if (clr) n.attempts = '0;
      if (!run) n.blocked = 1'b0;

      unique case (s.state)
         ST_POWERUP:
            if (s.tick)
            begin
               if (run && !s.ctrl[`SEQ_DIRECT_DIS])
               begin
                  n.state = ST_PU_DELAY;
                  n.tmr = 20'(s.bbr[`SEQ_DLY_DS] * `SEQ_TPD);
               end
               else
               begin
                  n.blocked = run;
                  n.state = ST_STOP;
               end
            end
         ST_PU_DELAY:
            if (!run) n.state = ST_STOP;
            else if (s.tmr == '0) do_start = 1'b1;
         ST_STOP:
            if (run && !s.blocked) do_start = 1'b1;
         ST_START_DCB:
            if (s.tmr == '0) n.state = ST_RUN;
         ST_RUN:
         begin
            if (s.tick && s.quiet != 16'(`SEQ_QUIET_TICKS))
               n.quiet = s.quiet + 16'h0001;
            if (s.quiet == 16'(`SEQ_QUIET_TICKS)) n.attempts = '0;
            if (!run)
            begin
               unique case (mode)
                  2'h0: n.state = ST_DECEL;
                  2'h2:
                  begin
                     n.state = ST_BASEBLOCK;
                     n.bbk = BB_DCSTOP;
                     n.tmr = bb_t;
                  end
                  default:
                  begin
                     n.state = ST_BASEBLOCK;
                     n.bbk = BB_COAST;
                     n.tmr = bb_t;
                  end
               endcase
            end
         end
         ST_DECEL:
            if (run) n.state = ST_RUN;
            else if (out_freq_in <= thr_eff)
            begin
               n.state = dcs_en ? ST_STOP_DCB : ST_STOP;
               n.tmr = 20'(s.dcsr[`SEQ_DC_STOP]);
            end
         ST_STOP_DCB:
            if (s.tmr == '0) n.state = ST_STOP;
         ST_BASEBLOCK:
            if (s.tmr == '0)
            begin
               unique case (s.bbk)
                  BB_COAST: n.state = ST_STOP;
                  BB_DCSTOP:
                  begin
                     n.state = dcs_en ? ST_STOP_DCB : ST_STOP;
                     n.tmr = 20'(s.dcsr[`SEQ_DC_STOP]);
                  end
                  BB_POWER:
                     if (sok) n.state = run ? ST_SEARCH : ST_STOP;
                  BB_FAULT:
                     if (s.flt_rt && !s.flt_other && !s.flt_low &&
                        s.attempts < s.tim[`SEQ_RT_LIM])
                     begin
                        n.attempts = s.attempts + 4'h1;
                        n.flt_rt = 1'b0;
                        n.state = ST_SEARCH;
                     end
                     else
                        n.state = ST_TRIPPED;
               endcase
            end
         ST_SEARCH:
            if (!run) n.state = ST_STOP;
            else if (speed_search_done_in) n.state = ST_RUN;
         ST_TRIPPED:
            if (clr)
            begin
               n.state = ST_STOP;
               n.flt_rt = 1'b0;
               n.flt_other = 1'b0;
               n.flt_low = 1'b0;
            end
         default: n.state = ST_STOP;
      endcase

      if (do_start)
      begin
         if (dcp_en)
         begin
            n.state = ST_START_DCB;
            n.tmr = 20'(s.dcsr[`SEQ_DC_START]);
         end
         else
         begin
            n.state = ST_RUN;
            start_min = 1'b1;
         end
      end

      // Faults and supply loss override any running sequence
      fault_now = oth | rt | (!s.ctrl[`SEQ_RESTART_EN] & loss_long);
      if (running && (fault_now || (s.ctrl[`SEQ_RESTART_EN] && !sok)))
      begin
         n.state = ST_BASEBLOCK;
         n.quiet = '0;
         if (fault_now)
         begin
            n.bbk = BB_FAULT;
            n.tmr = ivl;
            n.flt_other = oth;
            n.flt_rt = rt;
            n.flt_low = !s.ctrl[`SEQ_RESTART_EN] & loss_long;
         end
         else
         begin
            n.bbk = BB_POWER;
            n.tmr = bb_t;
         end
      end

      // Registered outputs decoded from the next state
      n.dcb = (n.state inside {ST_START_DCB, ST_STOP_DCB} ||
         (n.state == ST_STOP && dcc)) && !vec;
      n.oe = n.dcb || n.state inside {ST_RUN, ST_DECEL, ST_SEARCH};
      n.bblk = !n.oe;
      n.cur = n.dcb ? s.dcbr[`SEQ_DC_CUR] : 7'h00;
      n.dec = n.state == ST_DECEL;
      n.minf = start_min;
      n.srch = n.state == ST_SEARCH;
      n.fcon = n.state == ST_TRIPPED;
      n.fact = n.fcon || (n.state == ST_BASEBLOCK && n.bbk == BB_FAULT);
      n.flash = n.blocked & n.blink[4];
   end

   // Reset stands for a power cycle and so clears the attempt count too
   always_ff @(posedge clk_in)
   begin
      if (!rstn_in) s <= RST;
      else s <= n;
   end

   assign readdata_out = s.rdata;
   assign waitrequest_out = s.wreq;
   assign output_enable_out = s.oe;
   assign baseblock_out = s.bblk;
   assign dc_brake_out = s.dcb;
   assign dc_brake_current_out = s.cur;
   assign decel_req_out = s.dec;
   assign start_min_freq_out = s.minf;
   assign speed_search_out = s.srch;
   assign fault_active_out = s.fact;
   assign fault_contact_out = s.fcon;
   assign powerup_run_blocked_indication_out = s.flash;

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rstn_in);

   AST_LOSS_TRIP: assert property (
      running && !s.ctrl[`SEQ_RESTART_EN] && loss_long |=>
         !output_enable_out && fault_active_out)
      else $error("long supply loss did not trip");
   AST_LOSS_RESUME: assert property (
      s.state == ST_BASEBLOCK && s.bbk == BB_POWER && s.tmr == '0 &&
      sok && run |=> s.state == ST_SEARCH || s.state == ST_BASEBLOCK)
      else $error("no resume after supply return");
   AST_INTERVAL: assert property (
      $rose(fault_active_out) && s.state == ST_BASEBLOCK |->
         s.tmr == $past(ivl))
      else $error("restart interval loaded wrong");
   AST_QUIET_CLEAR: assert property (
      s.state == ST_RUN && s.quiet == 16'(`SEQ_QUIET_TICKS) |=>
         s.attempts == '0)
      else $error("attempts not cleared after quiet time");
   AST_CLEAR_CMD: assert property (
      clr && s.state != ST_BASEBLOCK |=> s.attempts == '0)
      else $error("fault clear kept attempts");
   AST_BB_HOLD: assert property (
      s.state == ST_BASEBLOCK && s.tmr != '0 |=>
         !output_enable_out && s.state == ST_BASEBLOCK)
      else $error("output during baseblock");
   AST_TRIP_CONTACT: assert property (
      s.state == ST_TRIPPED |-> fault_contact_out && !output_enable_out)
      else $error("trip without contact");
   AST_ATTEMPT_LIMIT: assert property (
      s.state == ST_SEARCH |-> s.attempts <= s.tim[`SEQ_RT_LIM] ||
         s.attempts == '0)
      else $error("attempts beyond limit");
   AST_BLOCKED: assert property (
      s.state == ST_STOP && s.blocked |=> s.state == ST_STOP)
      else $error("started from run held at power-up");
   AST_VEC_NO_DCB: assert property (
      $past(vec) |-> !dc_brake_out)
      else $error("braking under sensor vector control");
   AST_DECEL_DCB: assert property (
      s.state == ST_DECEL && !run && out_freq_in <= thr_eff && dcs_en &&
      !fault_now |=> s.state == ST_STOP_DCB ##1 dc_brake_out)
      else $error("decel did not brake at threshold");

endmodule // drive_start_stop_restart_sequencer

// *** power_stage_model.sv ***
// Model of the power stage and motor behind the sequencer
module power_stage_model
(
   // Clock
   input wire logic clk_in,
   // From the sequencer, except slow_in from the bench
   input wire logic enable_in,
   input wire logic decel_in,
   input wire logic brake_in,
   input wire logic search_in,
   input wire logic slow_in,
   // To the sequencer
   output logic [15:0] freq_out,
   output logic search_done_out
);
   timeunit 1ns;
   timeprecision 1ns;
   int n = 0;
   initial freq_out = 16'h0000;
   initial search_done_out = 1'b0;
   // ****************************************
   // Motor frequency and speed search answer
   // ****************************************
   // Coasting or braked motor reads as zero, so no stale speed is seen
   always @(posedge clk_in)
   begin
      if (!enable_in || brake_in)
         freq_out <= 16'h0000;
      else if (decel_in)
         freq_out <= (freq_out > 16'h0032) ? freq_out - 16'h0032 : 16'h0000;
      else if (freq_out < 16'h1770)
         freq_out <= freq_out + 16'h0064;
      n <= search_in ? n + 1 : 0;
      // Slow answer exercises a long search
      search_done_out <= search_in && (n >= (slow_in ? 30 : 2));
   end
endmodule // power_stage_model

// *** drive_start_stop_restart_sequencer_tb.sv ***
// Self-checking bench of the start, stop and restart sequencer
module drive_start_stop_restart_sequencer_tb;
   import seq_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int TK = 10;
   logic clk_in = 0;
   logic rstn_in = 0;
   logic [7:0] address_in = 8'h00;
   logic read_in = 0;
   logic write_in = 0;
   logic [31:0] writedata_in = 32'h00000000;
   logic [3:0] byteenable_in = 4'hF;
   logic run_in = 1;
   logic supply_ok_in = 1;
   logic fault_reset_in = 0;
   logic dc_brake_cmd_in = 0;
   logic other_fault_in = 0;
   logic [8:0] rflt = 9'h000;
   logic slow = 0;
   logic [15:0] out_freq_in;
   logic speed_search_done_in, waitrequest_out, output_enable_out;
   logic [31:0] readdata_out;
   logic [6:0] dc_brake_current_out;
   logic baseblock_out, dc_brake_out, decel_req_out, start_min_freq_out;
   logic speed_search_out, fault_active_out, fault_contact_out;
   logic powerup_run_blocked_indication_out;
   logic [7:0] rnd;
   int errors = 0;
   int n_tests = 0;

   drive_start_stop_restart_sequencer #(.TICK_CYCLES(TK), .LOSS_CYCLES(8)) dut
   (
      .overcurrent_fault_in(rflt[0]),
      .overvoltage_fault_in(rflt[1]),
      .motor_overload_fault_in(rflt[2]),
      .drive_overload_fault_in(rflt[3]),
      .low_torque_fault_in(rflt[4]),
      .high_torque_fault_in(rflt[5]),
      .input_phase_loss_fault_in(rflt[6]),
      .output_phase_loss_fault_in(rflt[7]),
      .ground_fault_in(rflt[8]),
      .*
   );

   power_stage_model stage
   (
      .clk_in(clk_in),
      .enable_in(output_enable_out),
      .decel_in(decel_req_out),
      .brake_in(dc_brake_out),
      .search_in(speed_search_out),
      .slow_in(slow),
      .freq_out(out_freq_in),
      .search_done_out(speed_search_done_in)
   );

   initial
   begin
      forever #10 clk_in = ~clk_in;
   end

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [7:0] lfsr(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_in);
   endtask

   // Holds the request until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      int k;
      k = 0;
      address_in <= a;
      writedata_in <= d;
      write_in <= wr;
      read_in <= !wr;
      do
      begin
         @(posedge clk_in);
         k++;
      end
      while (waitrequest_out !== 1'b0);
      q = readdata_out;
      chk(k, 2);
      write_in <= 0;
      read_in <= 0;
      @(posedge clk_in);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1, a, d, q);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(0, a, 32'h00000000, q);
      chk(q, exp);
   endtask

   task automatic wait_sig(ref logic s, input logic v, input int lim,
                           output int n);
      n = 0;
      while (s !== v && n < lim)
      begin
         @(posedge clk_in);
         n++;
      end
      chk(s, v);
   endtask

   task automatic conclude;
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   initial
   begin
      cyc(40000);
      errors++;
      conclude();
   end

   // ****************************************
   // Tests
   // ****************************************
   initial
   begin
      int n;
      int iv;
      logic [6:0] cur;
      rnd = 8'h3D;
      cyc(4);
      rstn_in <= 1;
      rdc(8'h08, 32'h000A0005);
      rdc(8'h14, 32'h00000096);
      rdc(8'h00, 32'h00000000);
      rdc(8'h1C, 32'h00000000);
      cyc(800);
      chk(output_enable_out, 0);
      wait_sig(output_enable_out, 1, 400, n);
      $display("test direct start done");
      wr(8'h00, 32'h00000001);
      for (int i = 0; i < 9; i++)
      begin
         wr(8'h04, {12'h000, 4'hA, 3'h0, 13'(i == 0)});
         iv = (i == 0) ? 100 * TK : 50 * TK;
         slow <= i[0];
         rflt[i] <= 1;
         cyc(8);
         rflt[i] <= 0;
         chk({output_enable_out, fault_active_out}, 2'b01);
         wait_sig(speed_search_out, 1, iv + 60, n);
         chk(n + 8 >= iv - 25 && n + 8 <= iv + 25, 1);
         wait_sig(speed_search_out, 0, 60, n);
         chk(output_enable_out, 1);
         rdc(8'h18, 32'((i + 1) * 16 + 4));
      end
      $display("test auto restart done");
      wr(8'h04, 32'h00090000);
      rflt[0] <= 1;
      cyc(8);
      rflt[0] <= 0;
      cyc(600);
      chk({output_enable_out, fault_contact_out}, 2'b01);
      rdc(8'h18, 32'h00001299);
      run_in <= 0;
      fault_reset_in <= 1;
      cyc(8);
      fault_reset_in <= 0;
      cyc(4);
      rdc(8'h18, 32'h00000002);
      run_in <= 1;
      wait_sig(output_enable_out, 1, 30, n);
      other_fault_in <= 1;
      cyc(8);
      other_fault_in <= 0;
      cyc(700);
      chk({output_enable_out, fault_contact_out}, 2'b01);
      run_in <= 0;
      cyc(8);
      wr(8'h00, 32'h00000040);
      chk(fault_contact_out, 0);
      $display("test limit and clear done");
      run_in <= 1;
      wait_sig(output_enable_out, 1, 30, n);
      supply_ok_in <= 0;
      cyc(4);
      supply_ok_in <= 1;
      cyc(20);
      chk(output_enable_out, 1);
      supply_ok_in <= 0;
      wait_sig(fault_active_out, 1, 40, n);
      wait_sig(fault_contact_out, 1, 600, n);
      rdc(8'h18, 32'h00001109);
      supply_ok_in <= 1;
      run_in <= 0;
      cyc(8);
      wr(8'h00, 32'h00000041);
      run_in <= 1;
      wait_sig(output_enable_out, 1, 30, n);
      supply_ok_in <= 0;
      wait_sig(output_enable_out, 0, 40, n);
      supply_ok_in <= 1;
      wait_sig(output_enable_out, 1, 700, n);
      $display("test supply loss done");
      rnd = lfsr(rnd);
      cur = 7'(rnd % 100 + 1);
      wr(8'h0C, {14'h0000, 10'h1F4, 1'b0, cur});
      wr(8'h10, 32'h0000000A);
      cyc(100);
      run_in <= 0;
      wait_sig(decel_req_out, 1, 20, n);
      wait_sig(dc_brake_out, 1, 200, n);
      chk(out_freq_in <= 16'h01F4, 1);
      chk(dc_brake_current_out, cur);
      wait_sig(dc_brake_out, 0, 200, n);
      chk(n >= 90 && n <= 112, 1);
      dc_brake_cmd_in <= 1;
      wait_sig(dc_brake_out, 1, 10, n);
      dc_brake_cmd_in <= 0;
      wr(8'h00, 32'h00000020);
      dc_brake_cmd_in <= 1;
      cyc(20);
      chk(dc_brake_out, 0);
      dc_brake_cmd_in <= 0;
      $display("test braking done");
      // Power cycle with run held: direct start disabled before first tick
      run_in <= 1;
      rstn_in <= 0;
      cyc(4);
      rstn_in <= 1;
      wr(8'h00, 32'h00000002);
      cyc(400);
      chk(output_enable_out, 0);
      rdc(8'h18, 32'h00000802);
      wait_sig(powerup_run_blocked_indication_out, 1, 400, n);
      run_in <= 0;
      cyc(8);
      run_in <= 1;
      wait_sig(output_enable_out, 1, 30, n);
      chk({start_min_freq_out, baseblock_out}, 2'b10);
      wr(8'h00, 32'h00000004);
      run_in <= 0;
      wait_sig(output_enable_out, 0, 20, n);
      run_in <= 1;
      cyc(100);
      chk(output_enable_out, 0);
      wait_sig(output_enable_out, 1, 600, n);
      wr(8'h00, 32'h00000014);
      run_in <= 0;
      wait_sig(decel_req_out, 1, 20, n);
      $display("test power cycle and stop modes done");
      conclude();
   end
endmodule // drive_start_stop_restart_sequencer_tb
